// file: svm_pkg.sv
// Package for the supply monitor control block: register offsets, field
// positions, reset values and timing constants.
// Assumes a plain address/strobe register port with 12-bit addresses.
package svm_pkg;

  // Register offsets (byte addresses on the plain register port)
  localparam logic [11:0] SVM_CTRL_OFS = 12'h0f2a;
  localparam logic [11:0] SVM_LSEL_OFS = 12'h0f2b;
  // Flag register, placed next to the two control registers
  localparam logic [11:0] SVM_FLAG_OFS = 12'h0f2c;

  // Control register field positions
  localparam int SVM_EN_BIT   = 7;
  localparam int SVM_OUT_BIT  = 5;
  localparam int SVM_RDY_BIT  = 4;
  localparam int SVM_RISE_BIT = 1;
  localparam int SVM_FALL_BIT = 0;
  // Flag register field positions
  localparam int SVM_FLAG_BIT = 0;
  localparam int SVM_IE_BIT   = 1;

  // Selector reset value and reserved code
  localparam logic [3:0] SVM_LSEL_RST = 4'h0;
  localparam logic [3:0] SVM_LSEL_RSVD = 4'hf;

  // Reference settle time in ns, and its cycle count at 100 MHz (rounded up)
  localparam int SVM_CLK_PERIOD_NS = 10;
  localparam int SVM_SETTLE_NS     = 25000;
  localparam int SVM_SETTLE_CYC    =
    (SVM_SETTLE_NS + SVM_CLK_PERIOD_NS - 1) / SVM_CLK_PERIOD_NS;

endpackage

// file: svm_sync.sv
// Two-flop synchroniser for asynchronous single-bit levels.
// Assumes the input is a level that changes slowly compared with mclk.
`timescale 1ns/1ps
`default_nettype none
module svm_sync #(
  parameter int W = 2
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_r;  // First stage, read only by the second

  // Two stages into the mclk domain
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule
`default_nettype wire

// file: svm_ctrl.sv
// Supply-voltage monitor control: registers, event flag and ready gating.
// Assumes the analog comparator and reference-ready levels are asynchronous,
// and that power-on/brown-out reset is flagged by a same-clock input.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE1: Four-bit level selector; code 1111 reserved.
// RULE2: Supply reaching trip level sets event flag.
// RULE3: Rise enable flags supply at/above level.
// RULE4: Fall enable flags supply at/below level.
// RULE5: Both enables flag either direction.
// RULE6: Enable bit switches monitor; off means no events.
// RULE7: Status bit 5 shows supply below level.
// RULE8: Ready bit shows reference settled.
// RULE9: No flag nor wake before ready.
// RULE10: Settling timed by analog, not clock count.
// RULE11: Cleared flag resets while condition holds.
// RULE12: Software sets level, directions, enable, clears flag.
// RULE13: Software disables before changing settings.
// RULE14: Toggling enable makes no spurious event.
// RULE15: Keeps working asleep; event wakes device.
// RULE16: Stays active in idle and doze.
// RULE17: Any reset clears enable and directions.
// RULE18: Selector reset only on power/brownout.
// RULE19: Comparator and ready pass two flops.
// RULE20: Level detection sets flag every cycle.
module svm_ctrl (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        por_bor,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        cmp_below,
  input  wire logic        ref_ready,
  output logic             mon_enable,
  output logic      [3:0]  level_select,
  output logic             level_valid,
  output logic             voltage_event_flag,
  output logic             voltage_event_irq,
  output logic             wake_request
);

  // Software state
  logic       en_r;        // Monitor enable
  logic       rise_r;      // Rise-detect enable
  logic       fall_r;      // Fall-detect enable
  logic [3:0] lsel_r;      // Trip-level selector
  logic       flag_r;      // Event flag
  logic       ie_r;        // Event interrupt enable
  logic [7:0] rdata_r;     // Read data register
  logic [3:0] lsel_nxt;    // Next selector value
  logic       lvalid_r;    // Selector holds a usable code
  logic       irq_r;       // Interrupt output
  logic       wake_r;      // Wake request output

  // Synchronised analog levels
  logic [1:0] sync_out;
  logic       below_s;     // Supply at or below level
  logic       rdy_s;       // Reference ready

  // Both asynchronous levels cross into mclk here [RULE19]
  svm_sync #(
    .W (2)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  ({cmp_below, ref_ready}),
    .dout (sync_out)
  );

  // Ready only counts while enabled; the analog reference times itself [RULE10]
  assign below_s = sync_out[1];
  assign rdy_s   = sync_out[0] & en_r; // [RULE8]

  // Register decode
  wire wr_ctrl = reg_wr & (reg_addr == svm_pkg::SVM_CTRL_OFS);
  wire wr_lsel = reg_wr & (reg_addr == svm_pkg::SVM_LSEL_OFS);
  wire wr_flag = reg_wr & (reg_addr == svm_pkg::SVM_FLAG_OFS);
  wire rd_ctrl = reg_addr == svm_pkg::SVM_CTRL_OFS;
  wire rd_lsel = reg_addr == svm_pkg::SVM_LSEL_OFS;
  wire rd_flag = reg_addr == svm_pkg::SVM_FLAG_OFS;

  // Level-based detection, gated by enable and ready [RULE2] [RULE6] [RULE9] [RULE20]
  wire rise_hit = rise_r & ~below_s;  // [RULE3]
  wire fall_hit = fall_r & below_s;   // [RULE4]
  // Either enable alone or both together [RULE5]
  wire det_set  = en_r & rdy_s & lvalid_r & (rise_hit | fall_hit);
  // Detection is level-based, so an enable edge alone flags nothing unless the condition holds [RULE14]

  // Readback image of the control register
  wire [7:0] ctrl_img = {en_r, 1'b0, below_s & rdy_s, rdy_s, 2'b00, rise_r, fall_r}; // [RULE7]
  wire [7:0] rd_mux   = rd_ctrl ? ctrl_img :
                        rd_lsel ? {4'h0, lsel_r} :
                        rd_flag ? {6'h00, ie_r, flag_r} : 8'h00;

  // Selector next value
  assign lsel_nxt = wr_lsel ? reg_wdata[3:0] : lsel_r;

  // Control bits take the reset value on any reset [RULE17]
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      en_r   <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
      ie_r   <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        en_r   <= reg_wdata[svm_pkg::SVM_EN_BIT];
        rise_r <= reg_wdata[svm_pkg::SVM_RISE_BIT];
        fall_r <= reg_wdata[svm_pkg::SVM_FALL_BIT];
      end
      if (wr_flag) begin
        ie_r <= reg_wdata[svm_pkg::SVM_IE_BIT];
      end
    end
  end

  // Selector kept across ordinary resets, cleared on power/brownout [RULE18]
  always_ff @(posedge mclk) begin
    if (por_bor) begin
      lsel_r <= svm_pkg::SVM_LSEL_RST;
    end else begin
      lsel_r <= lsel_nxt;
    end
  end

  // Reserved code gives no detection [RULE1]
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lvalid_r <= 1'b0;
    end else begin
      lvalid_r <= (lsel_r != svm_pkg::SVM_LSEL_RSVD);
    end
  end

  // Event flag: set wins over a software clear [RULE11]
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (det_set) begin
      flag_r <= 1'b1;
    end else if (wr_flag) begin
      flag_r <= reg_wdata[svm_pkg::SVM_FLAG_BIT];
    end
  end

  // Interrupt and wake; no clock gating so sleep, idle, doze keep it live [RULE15] [RULE16]
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_r  <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      irq_r  <= flag_r & ie_r;
      wake_r <= flag_r & ie_r;
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Outputs to the analog side; selector passed on whatever its code, with level_valid beside it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mon_enable   <= 1'b0;
      level_select <= 4'h0;
      level_valid  <= 1'b0;
    end else begin
      mon_enable   <= en_r;
      level_select <= lsel_r;
      level_valid  <= lvalid_r;
    end
  end

  assign reg_rdata          = rdata_r;
  assign voltage_event_flag = flag_r;
  assign voltage_event_irq  = irq_r;
  assign wake_request       = wake_r;

endmodule
`default_nettype wire

// file: svm_ctrl_assertions.sv
// Port checker for the supply monitor control block.
// Assumes one clock domain; bound onto svm_ctrl below.
`timescale 1ns/1ps
`default_nettype none
module svm_chk (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [11:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        ref_ready,
  input wire logic        mon_enable,
  input wire logic [3:0]  level_select,
  input wire logic        level_valid,
  input wire logic        voltage_event_flag,
  input wire logic        voltage_event_irq,
  input wire logic        wake_request
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Read hits on each register
  wire c_rd = reg_rd && reg_addr == svm_pkg::SVM_CTRL_OFS;
  wire l_rd = reg_rd && reg_addr == svm_pkg::SVM_LSEL_OFS;
  wire f_rd = reg_rd && reg_addr == svm_pkg::SVM_FLAG_OFS;
  AST_RST: assert property (
    $past(rst) |-> !mon_enable && !voltage_event_flag) else $error("not off after reset");
  AST_GATE: assert property (
    $rose(voltage_event_flag) && !$past(reg_wr) |-> mon_enable && $past(ref_ready, 3))
    else $error("flag set while off or not ready");
  AST_IRQ: assert property (
    voltage_event_irq |-> $past(voltage_event_flag)) else $error("irq without flag");
  AST_WAKE: assert property (
    wake_request == voltage_event_irq) else $error("wake differs from irq");
  AST_LV: assert property (
    !$past(rst) && !$past(rst, 2) && !$past(rst, 3)
    |-> level_valid == ($past(level_select) != 4'hf)) else $error("level_valid wrong");
  AST_CTL: assert property (
    c_rd |=> reg_rdata[7] == mon_enable && (!reg_rdata[4] || mon_enable))
    else $error("control image wrong");
  AST_SEL: assert property (
    l_rd |=> reg_rdata[3:0] == level_select) else $error("selector image wrong");
  AST_FLAG: assert property (
    f_rd |=> reg_rdata[0] == $past(voltage_event_flag)) else $error("flag image wrong");
  // Main scenarios
  cover property ($rose(voltage_event_flag));
  cover property (voltage_event_irq);
  cover property (l_rd);
endmodule
bind svm_ctrl svm_chk u_chk (.mclk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
  .ref_ready, .mon_enable, .level_select, .level_valid, .voltage_event_flag,
  .voltage_event_irq, .wake_request);
`default_nettype wire

// file: svm_ctrl_bench.sv
// Self-checking bench for the supply monitor control block.
// Assumes a 100 MHz clock and the svm_pkg register map.
`timescale 1ns/1ps
`default_nettype none
module svm_ctrl_bench;
  logic        mclk, rst, por_bor, reg_wr, reg_rd, cmp_below, ref_ready;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, d;
  logic        mon_enable, level_valid, voltage_event_flag, voltage_event_irq, wake_request;
  logic [3:0]  level_select;
  logic [15:0] r;
  int          err_count = 0, num_checks = 0;
  localparam logic [11:0] C = svm_pkg::SVM_CTRL_OFS, L = svm_pkg::SVM_LSEL_OFS;
  localparam logic [11:0] F = svm_pkg::SVM_FLAG_OFS;
  // Rows: {exp flag, below}, control value, selector
  logic [15:0] rows [8] = '{16'h2820, 16'h1820, 16'h3813, 16'h0813,
                            16'h283e, 16'h383e, 16'h1037, 16'h181f};
  svm_ctrl u_dut (.mclk, .rst, .por_bor, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cmp_below, .ref_ready, .mon_enable, .level_select, .level_valid,
    .voltage_event_flag, .voltage_event_irq, .wake_request);
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1;
    @(posedge mclk);
    reg_wr <= 0;
  endtask
  // Read strobe, data taken in the following cycle
  task automatic rd(input logic [11:0] a);
    @(posedge mclk);
    reg_addr <= a; reg_rd <= 1;
    @(posedge mclk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100us;
    err_count++;
    end_sim();
  end
  initial begin
    {rst, por_bor, reg_wr, reg_rd, cmp_below, ref_ready} = 6'b110001;
    reg_addr = 0; reg_wdata = 0;
    wt(16);
    rst <= 0; por_bor <= 0;
    rd(C); chk("ctrl", 8'h00, d & 8'hb3);
    rd(L); chk("sel", 8'h00, d & 8'h0f);
    rd(12'h0f2d); chk("unmapped", 8'h00, d);
    // Direction, enable and selector table
    foreach (rows[i]) begin
      r = rows[i];
      // Disable, select level, set directions and enable, clear stale flag
      wr(C, 8'h00);
      cmp_below <= r[12];
      wr(L, {4'h0, r[3:0]}); wr(C, r[11:4]); wr(F, 8'h00);
      wt(8);
      rd(F); chk("flag", {7'h00, r[13]}, d & 8'h01);
      rd(C); chk("ctrl", {r[11], 1'b0, r[11] & r[12], r[11], 2'b00, r[5:4]}, d & 8'hb3);
    end
    // Events held off until ready
    wr(C, 8'h00); ref_ready <= 0; wr(L, 8'h04); wr(C, 8'h81); wr(F, 8'h00);
    wt(8);
    rd(F); chk("flag", 8'h00, d & 8'h01);
    rd(C); chk("rdy", 8'h00, d & 8'h10);
    ref_ready <= 1;
    wt(8);
    rd(F); chk("flag", 8'h01, d & 8'h01);
    wr(F, 8'h00); wt(6); rd(F); chk("flag", 8'h01, d & 8'h01);
    wr(F, 8'h02); wt(4);
    chk("irq", 8'h01, {7'h00, voltage_event_irq});
    chk("wake", 8'h01, {7'h00, wake_request});
    // Enable toggle with no condition
    wr(C, 8'h00); cmp_below <= 0; wr(F, 8'h00); wr(C, 8'h81); wt(8);
    rd(F); chk("flag", 8'h00, d & 8'h01);
    // Plain reset keeps the selector
    rst <= 1; wt(2); rst <= 0;
    rd(C); chk("ctrl", 8'h00, d & 8'hb3);
    rd(L); chk("sel", 8'h04, d & 8'h0f);
    chk("level_select", 8'h04, {4'h0, level_select});
    end_sim();
  end
endmodule
`default_nettype wire
